/* File: shared/irq_regs_defs.svh */
// offsets, field layouts, reset values and masks of the interrupt enable and priority registers
`ifndef IRQ_REGS_DEFS_SVH
`define IRQ_REGS_DEFS_SVH

// register indices on the plain register port
`define ENABLE_FOUR_ADDR 4'h0
`define PRIO_BASE_ADDR 4'h1
`define PRIO_LAST_ADDR 4'h7
`define FLAGS_ADDR 4'h8
`define SW_FLAG_CLEAR_ADDR 4'h9
`define STATUS_ADDR 4'ha
`define MASK_ADDR 4'hb
`define VECTOR_ADDR 4'hc

// enable register bit positions
`define AUDIO_LEFT_BIT 15
`define AUDIO_RIGHT_BIT 14
`define ENCODER_TWO_BIT 11
`define PWM_TWO_FAULT_BIT 10
`define PWM_TWO_ERROR_BIT 9
`define CAN_TX_BIT 6
`define XFER_CH_SEVEN_BIT 5
`define XFER_CH_SIX_BIT 4
`define CHECKSUM_BIT 3
`define SERIAL_TWO_ERR_BIT 2
`define SERIAL_ONE_ERR_BIT 1

// implemented bits of the enable register
`define ENABLE_MASK 16'hce7e
// all four priority fields implemented
`define PRIO_FULL_MASK 16'h7777
// priority register holding only the two upper fields and the low field
`define PRIO_NO_MID_MASK 16'h7707
// priority register with fields only at bits 10-8, 6-4, 2-0
`define PRIO_LOW3_MASK 16'h0777
// priority field reset: level 4 in every field
`define PRIO_RESET 16'h4444
`define ENABLE_RESET 16'h0000
`define PRIO_WIDTH 3
`define SRC_COUNT 28
`define IRQ_STATUS_MASK 2'h3

`endif

/* File: shared/irq_regs_pkg.sv */
// types shared by the interrupt enable and priority register block
package irq_regs_pkg;
  typedef logic [2:0] prio_level_t;
  typedef logic [4:0] src_index_t;
  typedef logic [15:0] reg_word_t;
endpackage

/* File: logic/prio_pick.sv */
// picks the highest-priority eligible source out of the request vector
`timescale 1ns/100ps
`include "irq_regs_defs.svh"
module prio_pick
  import irq_regs_pkg::*;
(
  input wire logic [`SRC_COUNT-1:0] eligible_in,
  input wire logic [`SRC_COUNT*3-1:0] levels_in,
  output logic found_out,
  output src_index_t index_out,
  output prio_level_t level_out
);
  // linear scan; lower index wins a tie, which keeps the order stable
  always_comb begin
    found_out = 1'b0;
    index_out = '0;
    level_out = '0;
    for (int i = 0; i < `SRC_COUNT; i++) begin
      if (eligible_in[i] && levels_in[i*3 +: 3] > level_out) begin
        found_out = 1'b1;
        index_out = src_index_t'(i);
        level_out = levels_in[i*3 +: 3];
      end
    end
  end
endmodule

/* File: logic/interrupt_enable_priority_regs.sv */
// interrupt enable and priority registers with request forwarding toward the processor
`timescale 1ns/100ps
`include "irq_regs_defs.svh"

// Notes on behaviour
// - disabled source blocked, flag may still set
// - code 001 is lowest level one
// - code 000 disables the source, flag may still set
// - unimplemented bits read zero, ignore writes
// - fields at 14-12, 10-8, 6-4, 2-0
// - channel six bit four, seven bit five
// - no audio converter keeps audio off cpu_irq_out; flag and status bit0 may still set
// - flag reads one after request raised, sources 0..15 only
module interrupt_enable_priority_regs
  import irq_regs_pkg::*;
#(
  parameter bit HAS_AUDIO = 1'b1
)
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  // request pulses: bits 0..10 enable-register sources, 11..27 priority-only sources
  input wire logic [`SRC_COUNT-1:0] src_req_in,
  output logic cpu_irq_out,
  output logic [4:0] cpu_irq_index_out,
  output logic [2:0] cpu_irq_level_out,
  output logic irq_out
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [15:0] enable;
    logic [6:0][15:0] prio;
    logic [`SRC_COUNT-1:0] flags;
    logic [1:0] status;
    logic [1:0] mask;
    logic [15:0] rdata;
    logic irq;
    logic [4:0] idx;
    logic [2:0] lvl;
    logic [`SRC_COUNT-1:0] req_s1;
    logic [`SRC_COUNT-1:0] req_s2;
    logic [`SRC_COUNT-1:0] req_s3;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic [`SRC_COUNT-1:0] enables;
  logic [`SRC_COUNT*3-1:0] levels;
  logic [`SRC_COUNT-1:0] eligible;
  logic [`SRC_COUNT-1:0] req_edge;
  logic pick_found;
  src_index_t pick_index;
  prio_level_t pick_level;

  // ==========================================================
  // helpers
  // implemented-bit mask of each priority register
  function automatic reg_word_t prio_mask(input logic [2:0] n);
    if (n == 3'd3) begin
      prio_mask = `PRIO_LOW3_MASK;
    end else if (n == 3'd5) begin
      prio_mask = `PRIO_NO_MID_MASK;
    end else begin
      prio_mask = `PRIO_FULL_MASK;
    end
  endfunction

  function automatic prio_level_t field(input reg_word_t w, input int pos);
    field = w[pos*4 +: 3];
  endfunction

  // the seven priority registers sit on consecutive indices; writes and reads share this
  function automatic logic is_prio_addr(input logic [3:0] a);
    is_prio_addr = (a >= `PRIO_BASE_ADDR) && (a <= `PRIO_LAST_ADDR);
  endfunction

  // register number inside the priority bank; only meaningful when is_prio_addr holds
  function automatic logic [2:0] prio_slot(input logic [3:0] a);
    prio_slot = 3'(a - `PRIO_BASE_ADDR);
  endfunction

  // ==========================================================
  // source map: enable bits and priority fields per source
  always_comb begin
    enables = '0;
    enables[0] = state_reg.enable[`AUDIO_LEFT_BIT] & HAS_AUDIO;
    enables[1] = state_reg.enable[`AUDIO_RIGHT_BIT] & HAS_AUDIO;
    enables[2] = state_reg.enable[`ENCODER_TWO_BIT];
    enables[3] = state_reg.enable[`PWM_TWO_FAULT_BIT];
    enables[4] = state_reg.enable[`PWM_TWO_ERROR_BIT];
    enables[5] = state_reg.enable[`CAN_TX_BIT];
    enables[6] = state_reg.enable[`XFER_CH_SEVEN_BIT];
    enables[7] = state_reg.enable[`XFER_CH_SIX_BIT];
    enables[8] = state_reg.enable[`CHECKSUM_BIT];
    enables[9] = state_reg.enable[`SERIAL_TWO_ERR_BIT];
    enables[10] = state_reg.enable[`SERIAL_ONE_ERR_BIT];
    // priority-only sources have their enable registers elsewhere; treated as enabled
    enables[`SRC_COUNT-1:11] = '1;
    // enable-register sources run at a fixed mid level; their fields live elsewhere
    levels = '0;
    for (int i = 0; i < 11; i++) begin
      levels[i*3 +: 3] = 3'h4;
    end
    // 17 sources with priority fields, registers 0..3 field 3 down to 0, then register 4 field 3 only
    for (int r = 0; r < 7; r++) begin
      for (int f = 0; f < 4; f++) begin
        if ((r*4 + (3-f)) < 17) begin
          levels[(11 + r*4 + (3-f))*3 +: 3] = field(state_reg.prio[r], f);
        end
      end
    end
  end

  // enabled and flagged; the nonzero level check is left to prio_pick, where 001 still counts, 000 never
  assign eligible = state_reg.flags & enables;

  // ==========================================================
  // arbitration
  prio_pick u_pick (
    .eligible_in(eligible),
    .levels_in(levels),
    .found_out(pick_found),
    .index_out(pick_index),
    .level_out(pick_level)
  );

  // edges of synchronised request inputs
  assign req_edge = state_reg.req_s2 & ~state_reg.req_s3;

  // ==========================================================
  // next-state logic
  always_comb begin
    logic [2:0] n;
    logic [15:0] clr;
    n = 3'd0;
    clr = '0;
    state_next = state_reg;
    state_next.req_s1 = src_req_in;
    state_next.req_s2 = state_reg.req_s1;
    state_next.req_s3 = state_reg.req_s2;
    state_next.rdata = '0;
    // register writes; unimplemented bits are masked away
    if (wr_in) begin
      if (addr_in == `ENABLE_FOUR_ADDR) begin
        state_next.enable = wdata_in & `ENABLE_MASK;
      end else if (is_prio_addr(addr_in)) begin
        n = prio_slot(addr_in);
        state_next.prio[n] = wdata_in & prio_mask(n);
      end else if (addr_in == `SW_FLAG_CLEAR_ADDR) begin
        clr = wdata_in;
      end else if (addr_in == `MASK_ADDR) begin
        state_next.mask = wdata_in[1:0];
      end
    end
    // flags: software clears one low word of flags, a new request wins
    // limitation: sources above the low word stay pending once set
    state_next.flags = (state_reg.flags & ~{12'h000, clr}) | req_edge;
    // status events: bit0 any new request, bit1 a new winner appeared
    if (wr_in && addr_in == `STATUS_ADDR) begin
      state_next.status = state_reg.status & ~wdata_in[1:0];
    end
    if (|req_edge) begin
      state_next.status[0] = 1'b1;
    end
    if (pick_found && !state_reg.irq) begin
      state_next.status[1] = 1'b1;
    end
    // reads answer in the following cycle
    if (rd_in) begin
      if (addr_in == `ENABLE_FOUR_ADDR) begin
        state_next.rdata = state_reg.enable;
      end else if (is_prio_addr(addr_in)) begin
        n = prio_slot(addr_in);
        state_next.rdata = state_reg.prio[n];
      end else if (addr_in == `FLAGS_ADDR) begin
        state_next.rdata = state_reg.flags[15:0];
      end else if (addr_in == `STATUS_ADDR) begin
        state_next.rdata = {14'h0000, state_reg.status};
      end else if (addr_in == `MASK_ADDR) begin
        state_next.rdata = {14'h0000, state_reg.mask};
      end else if (addr_in == `VECTOR_ADDR) begin
        state_next.rdata = {5'h00, state_reg.irq, 2'h0, state_reg.lvl, state_reg.idx};
      end
    end
    // presented request registered from the arbiter
    state_next.irq = pick_found;
    state_next.idx = pick_index;
    state_next.lvl = pick_level;
    if (reset_in) begin
      state_next = '0;
      state_next.enable = `ENABLE_RESET;
      for (int r = 0; r < 7; r++) begin
        state_next.prio[r] = `PRIO_RESET & prio_mask(3'(r));
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge core_clk_in) begin
    state_reg <= state_next;
  end

  assign rdata_out = state_reg.rdata;
  assign cpu_irq_out = state_reg.irq;
  assign cpu_irq_index_out = state_reg.idx;
  assign cpu_irq_level_out = state_reg.lvl;
  assign irq_out = |(state_reg.status & state_reg.mask);

  // ==========================================================
  // checks
  // source gating: enable bits, their placement and the converter option
  // a flagged enable-register source with its enable set raises the presented request
  a_enabled_fwd: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    eligible[7] |=> cpu_irq_out)
    else $error("enabled flagged source not forwarded");
  // a cleared enable keeps its source off the processor request
  a_blocked_src: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    !enables[6] |=> !(cpu_irq_out && cpu_irq_index_out == 5'h06))
    else $error("disabled source presented");
  // the flag still records a request while its enable is off
  a_flag_while_off: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    req_edge[7] && !enables[7] |=> state_reg.flags[7])
    else $error("flag lost while source disabled");
  // channel six transfer-complete enable lives at bit four
  a_ch_six_bit: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    enables[7] == state_reg.enable[4])
    else $error("channel six enable misplaced");
  // channel seven transfer-complete enable lives at bit five
  a_ch_seven_bit: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    enables[6] == state_reg.enable[5])
    else $error("channel seven enable misplaced");
  // without the converter the two audio sources are never presented
  a_audio_gone: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    !HAS_AUDIO |-> !(cpu_irq_out && cpu_irq_index_out < 5'h02))
    else $error("audio interrupt without converter");

  // priority decode and arbitration
  // a presented request always carries a nonzero level
  a_disabled_silent: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    cpu_irq_out |-> cpu_irq_level_out != 3'h0)
    else $error("presented interrupt at level zero");
  // a lone flagged source with code zero stays silent
  a_zero_blocks: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    eligible == 28'h0000800 && levels[35:33] == 3'h0 |=> !cpu_irq_out)
    else $error("level zero source presented");
  // code one is still a live level, the lowest one
  a_level_one: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    eligible == 28'h0000800 && levels[35:33] == 3'h1 |=> cpu_irq_level_out == 3'h1)
    else $error("level one not presented");
  // the presented level is the field code itself
  a_code_level: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    eligible == 28'h0000800 |=> cpu_irq_level_out == $past(state_reg.prio[0][14:12]))
    else $error("presented level differs from field code");
  // level seven always wins
  a_pick_highest: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    eligible[11] && levels[35:33] == 3'h7 |=> cpu_irq_out && cpu_irq_level_out == 3'h7)
    else $error("highest level not presented");
  // a strictly lower level never beats a pending higher one
  a_no_lower_win: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    eligible[12] && eligible[11] && levels[38:36] > levels[35:33] |=> cpu_irq_index_out != 5'h0b)
    else $error("lower level source presented");
  // nothing eligible means nothing presented
  a_idle_quiet: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    eligible == 28'h0000000 |=> !cpu_irq_out)
    else $error("request presented with nothing eligible");

  // register image
  // unimplemented enable bits never hold a one
  a_unimpl_zero: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    (state_reg.enable & ~`ENABLE_MASK) == 16'h0000)
    else $error("unimplemented enable bit set");
  // the gap bits between priority fields never hold a one
  a_gap_bits: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    (state_reg.prio & {7{16'h8888}}) == 112'h0)
    else $error("priority gap bit set");
  // a full priority register keeps exactly its four fields
  a_write_masked: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    wr_in && addr_in == `PRIO_BASE_ADDR |=> state_reg.prio[0] == $past(wdata_in & 16'h7777))
    else $error("priority write not stored");
  // indices past the last register answer zero
  a_unmapped_read: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    rd_in && addr_in > `VECTOR_ADDR |=> rdata_out == 16'h0000)
    else $error("unmapped index read nonzero");
  // the enable register reads zero in its unimplemented bits
  a_enable_read: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    rd_in && addr_in == `ENABLE_FOUR_ADDR |=> (rdata_out & ~`ENABLE_MASK) == 16'h0000)
    else $error("enable read shows unimplemented bits");
  // first edge after reset: level four everywhere, enables clear
  a_reset_level: assert property (
    @(posedge core_clk_in)
    $fell(reset_in) |-> state_reg.enable == 16'h0000 && state_reg.prio[0] == 16'h4444
      && state_reg.prio[3] == 16'h0444)
    else $error("reset values wrong");
  // outputs come out of reset quiet
  a_reset_quiet: assert property (
    @(posedge core_clk_in)
    $fell(reset_in) |-> !cpu_irq_out && !irq_out && rdata_out == 16'h0000)
    else $error("outputs active after reset");

  // flags and sticky status
  // a synchronised rising request sets its flag
  a_flag_set: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    req_edge[11] |=> state_reg.flags[11])
    else $error("flag not set by request");
  // a set flag of sources 0..15 reads back as one
  a_flag_read: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    rd_in && addr_in == `FLAGS_ADDR && state_reg.flags[7] |=> rdata_out[7])
    else $error("set flag reads zero");
  // any new request marks the status register
  a_status_new: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    |req_edge |=> state_reg.status[0])
    else $error("new request not recorded in status");
  // a fresh winner marks the status register
  a_status_winner: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    pick_found && !state_reg.irq |=> state_reg.status[1])
    else $error("new winner not recorded in status");
endmodule

/* File: sim/tb_interrupt_enable_priority_regs.sv */
// self-checking bench for the interrupt enable and priority register block
`timescale 1ns/100ps
`include "irq_regs_defs.svh"
module tb_interrupt_enable_priority_regs
  import irq_regs_pkg::*;
;
  // ==========================================
  // stimulus and observed signals
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [3:0] addr_in = 4'h0;
  reg_word_t wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [27:0] src_req_in = 28'h0000000;
  reg_word_t rdata_out;
  logic cpu_irq_out;
  logic [4:0] cpu_irq_index_out;
  logic [2:0] cpu_irq_level_out;
  logic irq_out;
  logic na_cpu_irq;
  int failures = 0;
  int tests_run = 0;
  reg_word_t s;

  interrupt_enable_priority_regs dut (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .src_req_in(src_req_in),
    .cpu_irq_out(cpu_irq_out),
    .cpu_irq_index_out(cpu_irq_index_out),
    .cpu_irq_level_out(cpu_irq_level_out),
    .irq_out(irq_out)
  );

  // second copy built without the audio converter; only its request output is watched
  interrupt_enable_priority_regs #(
    .HAS_AUDIO(1'b0)
  ) dut_no_audio (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(),
    .src_req_in(src_req_in),
    .cpu_irq_out(na_cpu_irq),
    .cpu_irq_index_out(),
    .cpu_irq_level_out(),
    .irq_out()
  );

  // 250 MHz core clock
  initial begin
    forever #2 core_clk_in = ~core_clk_in;
  end

  // ==========================================
  // shared tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input reg_word_t exp, input reg_word_t got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle strobes; the slave never stalls
  task automatic wr(input logic [3:0] a, input reg_word_t d);
    @(posedge core_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output reg_word_t d);
    @(posedge core_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a, input reg_word_t exp);
    reg_word_t d;
    rd(a, d);
    chk(what, exp, d);
  endtask

  // request line held long enough to pass the two-flop synchroniser
  task automatic pulse(input int i);
    @(posedge core_clk_in);
    src_req_in <= src_req_in | (28'h0000001 << i);
    repeat (4) @(posedge core_clk_in);
    src_req_in <= src_req_in & ~(28'h0000001 << i);
    repeat (4) @(posedge core_clk_in);
    #1;
  endtask

  task automatic chk_win(input logic [4:0] i, input logic [2:0] l);
    chk("winner", {7'h0, 1'b1, i, l}, {7'h0, cpu_irq_out, cpu_irq_index_out, cpu_irq_level_out});
  endtask

  function automatic reg_word_t pmask(input int i);
    pmask = (i == 4) ? `PRIO_LOW3_MASK : (i == 6) ? `PRIO_NO_MID_MASK : `PRIO_FULL_MASK;
  endfunction

  // ==========================================
  // scenarios
  task automatic t_reset_and_masks();
    rd_chk("enable", 4'h0, `ENABLE_RESET);
    for (int i = 1; i < 8; i++) begin
      rd_chk("prio", i[3:0], `PRIO_RESET & pmask(i));
    end
    wr(4'h0, 16'hffff);
    rd_chk("enable", 4'h0, `ENABLE_MASK);
    for (int i = 1; i < 8; i++) begin
      wr(i[3:0], 16'hffff);
      rd_chk("prio", i[3:0], pmask(i));
    end
    wr(4'he, 16'hffff);
    rd_chk("unmapped", 4'he, 16'h0000);
    wr(4'h0, 16'h0000);
  endtask

  // the two transfer channels: flag sets while blocked, forwards once enabled
  task automatic t_enable_gate();
    for (int k = 0; k < 2; k++) begin
      pulse(7 - k);
      rd_chk("flags", 4'h8, 16'h0001 << (7 - k));
      chk("cpu_irq", 16'h0000, {15'h0, cpu_irq_out});
      wr(4'h0, 16'h0010 << k);
      rd_chk("enable", 4'h0, 16'h0010 << k);
      repeat (3) @(posedge core_clk_in);
      #1;
      chk_win(5'(7 - k), 3'h4);
      wr(4'h9, 16'h0001 << (7 - k));
      wr(4'h0, 16'h0000);
      rd_chk("flags", 4'h8, 16'h0000);
    end
    // sticky status drives irq_out only while unmasked
    rd(4'ha, s);
    chk("status", 16'h0003, s);
    chk("irq_out", 16'h0000, {15'h0, irq_out});
    wr(4'hb, 16'h0003);
    #1;
    chk("irq_out", 16'h0001, {15'h0, irq_out});
    wr(4'ha, 16'h0003);
    #1;
    chk("irq_out", 16'h0000, {15'h0, irq_out});
    wr(4'hb, 16'h0000);
  endtask

  // audio sources: forwarded here, silent on the copy without the converter
  task automatic t_no_audio();
    wr(4'h0, 16'hc000);
    for (int k = 0; k < 2; k++) begin
      pulse(k);
      chk_win(5'(k), 3'h4);
      chk("no_audio_irq", 16'h0000, {15'h0, na_cpu_irq});
      rd_chk("flags", 4'h8, 16'h0001 << k);
      wr(4'h9, 16'h0001 << k);
    end
    wr(4'h0, 16'h0000);
  endtask

  // every priority code on the top field of the first priority register
  task automatic t_prio_codes();
    for (int c = 0; c < 8; c++) begin
      wr(4'h1, 16'(c) << 12);
      pulse(11);
      if (c == 0) begin
        chk("cpu_irq", 16'h0000, {15'h0, cpu_irq_out});
      end else begin
        chk_win(5'd11, 3'(c));
      end
      wr(4'h9, 16'h0800);
      repeat (4) @(posedge core_clk_in);
    end
  endtask

  // simultaneous requests: higher level wins, then the lower one follows
  task automatic t_arbitrate();
    wr(4'h1, 16'h2600);
    @(posedge core_clk_in);
    src_req_in[12:11] <= 2'b11;
    repeat (8) @(posedge core_clk_in);
    #1;
    chk_win(5'd12, 3'h6);
    rd_chk("vector", 4'hc, {5'h00, 1'b1, 2'h0, 3'h6, 5'h0c});
    wr(4'h9, 16'h1000);
    repeat (4) @(posedge core_clk_in);
    #1;
    chk_win(5'd11, 3'h2);
    @(posedge core_clk_in);
    src_req_in[12:11] <= 2'b00;
    wr(4'h9, 16'h0800);
  endtask

  // ==========================================
  // main sequence and hang guard
  initial begin
    repeat (10) @(posedge core_clk_in);
    reset_in <= 1'b0;
    t_reset_and_masks();
    t_enable_gate();
    t_no_audio();
    t_prio_codes();
    t_arbitrate();
    close_out();
  end

  initial begin
    repeat (20000) @(posedge core_clk_in);
    failures++;
    $display("Error run limit reached");
    close_out();
  end
endmodule
